// ### osc_select_and_clock_monitor.sv
// Overview of operation
// - The oscillator type input is sampled throughout reset and the value at release is held.
// - A held type of 0 picks the amplitude-limited oscillator, 1 the full-swing/external one.
// - The reference clock is a buffered copy of the crystal input; the logic itself runs on aclk.
// - The amplitude-limited oscillator runs low amplitude in low-power mode, else normal.
// - Missing reference edges for the whole timeout window declare a monitor failure.
// - A failure always enters self-clock mode; with its enable clear it also requests reset.
// - No failure is reported while disabled or while reference edges keep arriving.
// - The monitor works only while the clock-monitor enable bit is set.
// - A failure can raise an interrupt via self-clock mode or a reset via the reset path.
// - Entering or leaving self-clock mode sets a change flag, cleared by writing one or by reading the event register.
// - A monitor reset forces both enables to one and enters self-clock mode at once.
`timescale 1ns/1ps
module osc_select_and_clock_monitor #(
  parameter int TIMEOUT = osc_monitor_pkg::TIMEOUT_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [osc_monitor_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [osc_monitor_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [osc_monitor_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [osc_monitor_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_type_select,
  input wire logic crystal_input,
  input wire logic rc_osc_in,
  output logic osc_ref_clock,
  output logic colpitts_select,
  output logic pierce_select,
  output logic amplitude_low,
  output logic self_clock_mode,
  output logic system_reset_req,
  output logic irq
);
  import osc_monitor_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sel_meta_q;
  logic sel_sync_q;
  logic xtal_meta_q;
  logic xtal_sync_q;
  logic xtal_prev_q;
  logic rc_meta_q;
  logic rc_sync_q;
  logic rc_prev_q;

  // Left out of reset: the select strap must still be followed during reset
  always_ff @(posedge aclk) begin
    sel_meta_q <= osc_type_select;
    sel_sync_q <= sel_meta_q;
    xtal_meta_q <= crystal_input;
    xtal_sync_q <= xtal_meta_q;
    rc_meta_q <= rc_osc_in;
    rc_sync_q <= rc_meta_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Follow the pins in reset so release shows no false edge
      xtal_prev_q <= xtal_sync_q;
      rc_prev_q <= rc_sync_q;
    end else begin
      xtal_prev_q <= xtal_sync_q;
      rc_prev_q <= rc_sync_q;
    end
  end

  wire ref_rise = xtal_sync_q && !xtal_prev_q;
  wire rc_rise = rc_sync_q && !rc_prev_q;

  // ----------------------------------------------------------------
  // Oscillator type strap
  // ----------------------------------------------------------------
  osc_kind_type osc_kind_q;

  // Sampled every cycle of reset, so the last sample is the one at release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_kind_q <= sel_sync_q ? OSC_PIERCE : OSC_COLPITTS;
    end
  end

  wire is_colpitts = (osc_kind_q == OSC_COLPITTS);

  // ----------------------------------------------------------------
  // Control and interrupt registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic [EV_W-1:0] event_q;
  logic [EV_W-1:0] event_d;
  logic [EV_W-1:0] mask_q;
  logic [EV_W-1:0] mask_d;
  logic [FAILCNT_W-1:0] failcnt_q;
  logic [FAILCNT_W-1:0] failcnt_d;

  wire mon_en = ctrl_q[CTRL_MON_EN_BIT];
  wire self_en = ctrl_q[CTRL_SELF_EN_BIT];
  wire low_power = ctrl_q[CTRL_LOWPWR_BIT];

  // ----------------------------------------------------------------
  // Clock monitor
  // ----------------------------------------------------------------
  clock_monitor_if mon_bus ();

  assign mon_bus.enable = mon_en;
  assign mon_bus.ref_edge = ref_rise;
  assign mon_bus.rc_tick = rc_rise;

  clock_monitor #(
    .TIMEOUT(TIMEOUT)
  ) u_monitor (
    .aclk(aclk),
    .aresetn(aresetn),
    .bus(mon_bus.mon)
  );

  wire mon_fail = mon_bus.fail;

  // ----------------------------------------------------------------
  // Self-clock mode sequencing
  // ----------------------------------------------------------------
  clk_src_type src_q;
  clk_src_type src_d;
  logic rst_req_q;
  logic fail_prev_q;

  wire fail_rise = mon_fail && !fail_prev_q;
  wire mon_reset = fail_rise && !self_en;

  always_comb begin
    src_d = src_q;
    unique case (src_q)
      ST_REF_CLOCK: begin
        if (mon_fail) begin
          src_d = ST_SELF_CLOCK;
        end
      end
      ST_SELF_CLOCK: begin
        if (!mon_fail) begin
          src_d = ST_REF_CLOCK;
        end
      end
    endcase
  end

  wire src_change = (src_d != src_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_q <= ST_REF_CLOCK;
      rst_req_q <= 1'b0;
      fail_prev_q <= 1'b0;
    end else begin
      src_q <= src_d;
      rst_req_q <= mon_reset;
      fail_prev_q <= mon_fail;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave: write path
  // ----------------------------------------------------------------
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [DATA_W-1:0] rdata_q;

  // Address and data are taken together, whichever arrived first waits
  wire wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  wire [ADDR_W-1:0] wr_addr = {s_axi_awaddr[ADDR_W-1:2], 2'b00};
  wire wr_lane0 = wr_take && s_axi_wstrb[0];
  wire wr_ctrl = wr_lane0 && (wr_addr == CTRL_OFS);
  wire wr_event = wr_lane0 && (wr_addr == EVENT_OFS);
  wire wr_mask = wr_lane0 && (wr_addr == MASK_OFS);
  wire wr_failcnt = wr_lane0 && (wr_addr == FAILCNT_OFS);
  wire wr_hit = (wr_addr == CTRL_OFS) || (wr_addr == EVENT_OFS) ||
                (wr_addr == MASK_OFS) || (wr_addr == FAILCNT_OFS) ||
                (wr_addr == STATUS_OFS);

  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;

  // ----------------------------------------------------------------
  // AXI4-Lite slave: read path
  // ----------------------------------------------------------------
  wire rd_take = s_axi_arvalid && !rvalid_q;
  wire [ADDR_W-1:0] rd_addr = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire rd_event = rd_take && (rd_addr == EVENT_OFS);

  wire [STAT_W-1:0] status_word = {amplitude_low, mon_fail,
                                   (src_q == ST_SELF_CLOCK), !is_colpitts};

  wire rd_hit = (rd_addr == CTRL_OFS) || (rd_addr == STATUS_OFS) ||
                (rd_addr == EVENT_OFS) || (rd_addr == MASK_OFS) ||
                (rd_addr == FAILCNT_OFS);

  wire [DATA_W-1:0] rd_word =
    (rd_addr == CTRL_OFS) ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_q} :
    (rd_addr == STATUS_OFS) ? {{(DATA_W-STAT_W){1'b0}}, status_word} :
    (rd_addr == EVENT_OFS) ? {{(DATA_W-EV_W){1'b0}}, event_q} :
    (rd_addr == MASK_OFS) ? {{(DATA_W-EV_W){1'b0}}, mask_q} :
    (rd_addr == FAILCNT_OFS) ? {{(DATA_W-FAILCNT_W){1'b0}}, failcnt_q} :
    {DATA_W{1'b0}};

  assign s_axi_arready = rd_take;

  // ----------------------------------------------------------------
  // Register next values
  // ----------------------------------------------------------------
  wire [EV_W-1:0] ev_set = {mon_reset, src_change};
  wire [EV_W-1:0] ev_w1c = wr_event ? s_axi_wdata[EV_W-1:0] : {EV_W{1'b0}};
  wire [EV_W-1:0] ev_rdclr = rd_event ? {EV_W{1'b1}} : {EV_W{1'b0}};

  // Monitor reset overrides software so both enables come back set
  assign ctrl_d = mon_reset ? (ctrl_q | CTRL_RESET) :
                  wr_ctrl ? s_axi_wdata[CTRL_W-1:0] : ctrl_q;

  // A hardware set in the same cycle as a clear is kept
  assign event_d = (event_q & ~(ev_w1c | ev_rdclr)) | ev_set;
  assign mask_d = wr_mask ? s_axi_wdata[EV_W-1:0] : mask_q;

  assign failcnt_d = wr_failcnt ? {FAILCNT_W{1'b0}} :
                     (fail_rise && (failcnt_q != {FAILCNT_W{1'b1}})) ?
                     failcnt_q + FAILCNT_W'(1) : failcnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
      event_q <= EV_RESET;
      mask_q <= MASK_RESET;
      failcnt_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      event_q <= event_d;
      mask_q <= mask_d;
      failcnt_q <= failcnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_take) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_word;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Clock and oscillator outputs
  // ----------------------------------------------------------------
  logic ref_q;
  logic colp_q;
  logic amp_low_q;
  logic irq_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_q <= 1'b0;
      colp_q <= 1'b0;
      amp_low_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      ref_q <= xtal_sync_q;
      colp_q <= is_colpitts;
      amp_low_q <= is_colpitts && low_power;
      irq_q <= |(event_d & mask_d);
    end
  end

  // Sampled copy only; the analog buffer itself sits outside this logic
  assign osc_ref_clock = ref_q;
  assign colpitts_select = colp_q;
  assign pierce_select = !colp_q;
  assign amplitude_low = amp_low_q;
  assign self_clock_mode = (src_q == ST_SELF_CLOCK);
  assign system_reset_req = rst_req_q;
  assign irq = irq_q;

endmodule : osc_select_and_clock_monitor

// ### osc_monitor_pkg.sv
package osc_monitor_pkg;

  // ----------------------------------------------------------------
  // Bus geometry and answers
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] EVENT_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] MASK_OFS = 5'h0c;
  localparam logic [ADDR_W-1:0] FAILCNT_OFS = 5'h10;

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CTRL_MON_EN_BIT = 0;
  localparam int CTRL_SELF_EN_BIT = 1;
  localparam int CTRL_LOWPWR_BIT = 2;
  localparam int CTRL_W = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h3;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int STAT_OSC_TYPE_BIT = 0;
  localparam int STAT_SELF_CLK_BIT = 1;
  localparam int STAT_FAIL_BIT = 2;
  localparam int STAT_AMP_LOW_BIT = 3;
  localparam int STAT_W = 4;

  // ----------------------------------------------------------------
  // Event and mask fields
  // ----------------------------------------------------------------
  localparam int EV_SELF_CHANGE_BIT = 0;
  localparam int EV_MON_RESET_BIT = 1;
  localparam int EV_W = 2;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;
  localparam logic [EV_W-1:0] MASK_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Monitor timing
  // ----------------------------------------------------------------
  localparam int TIMEOUT_TICKS = 16;
  localparam int FAILCNT_W = 8;

  typedef enum logic {
    OSC_COLPITTS,
    OSC_PIERCE
  } osc_kind_type;

  typedef enum {
    ST_REF_CLOCK,
    ST_SELF_CLOCK
  } clk_src_type;

endpackage : osc_monitor_pkg

// ### clock_monitor_if.sv
`timescale 1ns/1ps
interface clock_monitor_if;
  logic enable;
  logic ref_edge;
  logic rc_tick;
  logic fail;

  modport ctrl (
    output enable,
    output ref_edge,
    output rc_tick,
    input fail
  );

  modport mon (
    input enable,
    input ref_edge,
    input rc_tick,
    output fail
  );
endinterface : clock_monitor_if

// ### clock_monitor.sv
`timescale 1ns/1ps
module clock_monitor #(
  parameter int TIMEOUT = osc_monitor_pkg::TIMEOUT_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  clock_monitor_if.mon bus
);
  import osc_monitor_pkg::*;

  localparam int CNT_W = $clog2(TIMEOUT + 1);
  localparam logic [CNT_W-1:0] TERMINAL = CNT_W'(TIMEOUT);

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic fail_q;
  logic at_terminal;

  // ----------------------------------------------------------------
  // Timeout counted in ticks of the independent RC source
  // ----------------------------------------------------------------
  assign at_terminal = (count_q == TERMINAL);
  assign count_d = (!bus.enable || bus.ref_edge) ? '0 :
                   (bus.rc_tick && !at_terminal) ? count_q + CNT_W'(1) : count_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= '0;
      fail_q <= 1'b0;
    end else begin
      count_q <= count_d;
      fail_q <= bus.enable && !bus.ref_edge && (count_d == TERMINAL);
    end
  end

  assign bus.fail = fail_q;

endmodule : clock_monitor

// ### osc_monitor_checker.sv
`timescale 1ns/1ps
module osc_monitor_checker #(
  parameter int TIMEOUT = osc_monitor_pkg::TIMEOUT_TICKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [osc_monitor_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic crystal_input,
  input wire logic osc_ref_clock,
  input wire logic colpitts_select,
  input wire logic pierce_select,
  input wire logic amplitude_low,
  input wire logic self_clock_mode,
  input wire logic system_reset_req
);
  import osc_monitor_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // --------------------------------
  // Cycles since release, saturating
  // --------------------------------
  logic [2:0] run_q;
  logic [2:0] run_d;
  assign run_d = (run_q == 3'h4) ? run_q : run_q + 3'h1;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 3'h0;
    end else begin
      run_q <= run_d;
    end
  end
  sequence reset_pulse;
    system_reset_req ##1 !system_reset_req;
  endsequence
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write take not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read take not answered");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  osc_choice_a: assert property (pierce_select != colpitts_select)
    else $error("oscillator selects not exclusive");
  strap_held_a: assert property (run_q == 3'h4 |-> $stable(colpitts_select))
    else $error("latched type changed after reset");
  ref_copy_a: assert property (run_q == 3'h4 |-> osc_ref_clock == $past(crystal_input, 3))
    else $error("reference clock not a copy of crystal");
  amp_colpitts_a: assert property (amplitude_low |-> colpitts_select)
    else $error("low amplitude outside amplitude-limited mode");
  mon_reset_a: assert property (system_reset_req |-> self_clock_mode ##0 reset_pulse)
    else $error("monitor reset without self-clock or too long");
endmodule : osc_monitor_checker

bind osc_select_and_clock_monitor osc_monitor_checker #(.TIMEOUT(TIMEOUT)) osc_monitor_checker_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .crystal_input(crystal_input), .osc_ref_clock(osc_ref_clock),
  .colpitts_select(colpitts_select), .pierce_select(pierce_select),
  .amplitude_low(amplitude_low), .self_clock_mode(self_clock_mode),
  .system_reset_req(system_reset_req));

// ### crystal_source.sv
`timescale 1ns/1ps
module crystal_source (
  input wire logic aclk,
  input wire logic run,
  output logic crystal_input
);
  logic [1:0] div_q = 2'h0;
  logic pin_q = 1'b0;
  // Eighth of aclk keeps it visible; stopped pin sits at its pull-down
  always @(posedge aclk) begin
    div_q <= div_q + 2'h1;
    if (!run) begin
      pin_q <= 1'b0;
    end else if (div_q == 2'h3) begin
      pin_q <= !pin_q;
    end
  end
  assign crystal_input = pin_q;
endmodule : crystal_source

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  import osc_monitor_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, osc_type_select = 1'b1, rc_osc_in = 1'b0;
  logic xtal_run = 1'b1;
  logic [4:0] awaddr = 5'h0, araddr = 5'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0] bresp, rresp, rs;
  logic [2:0] rc_div = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, crystal_input;
  logic osc_ref_clock, colpitts_select, pierce_select, amplitude_low;
  logic self_clock_mode, system_reset_req, irq;
  int err_count = 0, n_checks = 0, cyc = 0, rst_pulses = 0;

  osc_select_and_clock_monitor #(.TIMEOUT(4)) osc_select_and_clock_monitor_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .osc_type_select(osc_type_select),
    .crystal_input(crystal_input), .rc_osc_in(rc_osc_in), .osc_ref_clock(osc_ref_clock),
    .colpitts_select(colpitts_select), .pierce_select(pierce_select),
    .amplitude_low(amplitude_low), .self_clock_mode(self_clock_mode),
    .system_reset_req(system_reset_req), .irq(irq));
  crystal_source crystal_source_i (.aclk(aclk), .run(xtal_run), .crystal_input(crystal_input));

  always #5 aclk = ~aclk;
  // RC ticks every six cycles: fewer than the timeout per crystal period
  always @(posedge aclk) begin
    rc_div <= (rc_div == 3'h2) ? 3'h0 : rc_div + 3'h1;
    if (rc_div == 3'h2) rc_osc_in <= !rc_osc_in;
    if (system_reset_req === 1'b1) rst_pulses <= rst_pulses + 1;
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      end_sim;
    end
  end
  // --------------------------------
  // Bus and check tasks
  // --------------------------------
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic t;
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b0;
    do begin @(negedge aclk); t = awready; @(posedge aclk); end while (t !== 1'b1);
    awvalid <= 1'b0; wvalid <= 1'b0;
    @(posedge aclk);
    bready <= 1'b1;
    do begin @(negedge aclk); t = bvalid; rs = bresp; @(posedge aclk); end while (t !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, rs});
  endtask : wr
  task rd_reg(input logic [4:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic t;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b0;
    do begin @(negedge aclk); t = arready; @(posedge aclk); end while (t !== 1'b1);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do begin @(negedge aclk); t = rvalid; rd = rdata; rs = rresp; @(posedge aclk); end
    while (t !== 1'b1);
    chk("rdata", exp, rd);
    chk("rresp", {30'h0, er}, {30'h0, rs});
  endtask : rd_reg
  task wait_self(input logic v);
    int n;
    n = 0;
    while (self_clock_mode !== v && n < 300) begin @(negedge aclk); n++; end
    chk("self_clock_mode", {31'h0, v}, {31'h0, self_clock_mode});
    @(posedge aclk);
  endtask : wait_self
  task chk_irq(input logic v);
    @(negedge aclk);
    chk("irq", {31'h0, v}, {31'h0, irq});
    @(posedge aclk);
  endtask : chk_irq
  task do_reset(input logic strap);
    osc_type_select <= strap; aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : do_reset
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // --------------------------------
  // Tests
  // --------------------------------
  initial begin
    do_reset(1'b1);
    chk("pierce_select", 32'h1, {31'h0, pierce_select});
    osc_type_select <= 1'b0;
    rd_reg(CTRL_OFS, 32'h3, RESP_OKAY);
    rd_reg(EVENT_OFS, 32'h0, RESP_OKAY);
    rd_reg(MASK_OFS, 32'h0, RESP_OKAY);
    rd_reg(FAILCNT_OFS, 32'h0, RESP_OKAY);
    rd_reg(5'h14, 32'h0, RESP_SLVERR);
    wr(5'h14, 32'h1, RESP_SLVERR);
    wr(CTRL_OFS, 32'h7, RESP_OKAY);
    rd_reg(STATUS_OFS, 32'h1, RESP_OKAY);
    $display("test reset_values done");
    wr(MASK_OFS, 32'h1, RESP_OKAY);
    xtal_run <= 1'b0;
    wait_self(1'b1);
    chk_irq(1'b1);
    rd_reg(STATUS_OFS, 32'h7, RESP_OKAY);
    rd_reg(EVENT_OFS, 32'h1, RESP_OKAY);
    chk("rst_pulses", 32'h0, rst_pulses);
    xtal_run <= 1'b1;
    wait_self(1'b0);
    chk_irq(1'b1);
    wr(EVENT_OFS, 32'h1, RESP_OKAY);
    rd_reg(EVENT_OFS, 32'h0, RESP_OKAY);
    chk_irq(1'b0);
    rd_reg(FAILCNT_OFS, 32'h1, RESP_OKAY);
    $display("test self_clock done");
    wr(CTRL_OFS, 32'h2, RESP_OKAY);
    xtal_run <= 1'b0;
    repeat (100) @(posedge aclk);
    rd_reg(STATUS_OFS, 32'h1, RESP_OKAY);
    xtal_run <= 1'b1;
    repeat (20) @(posedge aclk);
    $display("test monitor_off done");
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    xtal_run <= 1'b0;
    wait_self(1'b1);
    // Pulse counter is updated by the edge just passed
    @(posedge aclk);
    chk("rst_pulses", 32'h1, rst_pulses);
    rd_reg(CTRL_OFS, 32'h3, RESP_OKAY);
    rd_reg(EVENT_OFS, 32'h3, RESP_OKAY);
    rd_reg(FAILCNT_OFS, 32'h2, RESP_OKAY);
    wr(FAILCNT_OFS, 32'h0, RESP_OKAY);
    rd_reg(FAILCNT_OFS, 32'h0, RESP_OKAY);
    xtal_run <= 1'b1;
    wait_self(1'b0);
    $display("test monitor_reset done");
    do_reset(1'b0);
    chk("colpitts_select", 32'h1, {31'h0, colpitts_select});
    wr(CTRL_OFS, 32'h7, RESP_OKAY);
    rd_reg(STATUS_OFS, 32'h8, RESP_OKAY);
    wr(CTRL_OFS, 32'h3, RESP_OKAY);
    rd_reg(STATUS_OFS, 32'h0, RESP_OKAY);
    $display("test colpitts done");
    end_sim;
  end
endmodule : testbench
